// ===== design/lrcd_decoder.sv
/*
  Remote command decoder for a programmable load: program select, sequence
  arm/run/pause/stop, run-state queries, labels, enable masks, status
  queries, reply format, error code, alarm reset, bus routing and lockout.
  Assumes one 50 MHz clock, an Avalon-MM master that holds each request
  until waitrequest is low, and a sequencer that reports step, loop, kind.
*/
// Contract
// - Store selected program 1..16 for later commands
// - Program query returns selected program
// - Last step 1..1024 stored for selected program
// - Arm enables run/pause/stop; pause halts, resumes
// - Run 1..8 starts that sequence
// - Stop halts sequence from any state
// - State query returns state, seq, prog, step, loop
// - Kind query returns sequence mode code
// - Memory label up to six characters, kept
// - Program label 1..16 with six-character comment
// - Service-request enable 0..255, queryable
// - Fault enable 0..255, queryable
// - Queries return summary, fault latch, live condition
// - Identity query returns model and revision
// - Terminator code 0..3 selectable and queryable
// - Header flag 0/1 selectable and queryable
// - Error query returns last error code
// - Reset command clears alarm state
// - Route 0..16 sets address; home forces 0
// - Address query returns 0 for broadcast
// - Lock command locks or releases front panel
// - Device clear returns bus address to 0
// - Error query clears summary error flag
// - Fault bits latch until fault query
`timescale 1ns/1ps

module lrcd_decoder #(
  parameter logic [15:0] MODEL_CODE    = 16'h0a5c, // Arbitrary value
  parameter logic [15:0] REVISION_CODE = 16'h0200  // Arbitrary value
) (
  input  wire logic              ref_clk,
  input  wire logic              rstn,
  input  wire logic [5:0]        avs_address,
  input  wire logic              avs_read,
  input  wire logic              avs_write,
  input  wire logic [31:0]       avs_writedata,
  input  wire logic [3:0]        avs_byteenable,
  output logic      [31:0]       avs_readdata,
  output logic                   avs_waitrequest,
  input  wire logic [7:0]        live_cond,
  input  wire logic              bus_srq,
  input  wire logic              seq_done,
  input  wire logic [3:0]        seq_kind,
  input  wire logic [4:0]        run_prog,
  input  wire logic [10:0]       run_step,
  input  wire logic [13:0]       run_loop,
  input  wire logic              dev_clear,
  output logic                   exec_mode,
  output logic [1:0]             run_state,
  output logic [3:0]             run_seq,
  output logic                   seq_start,
  output logic                   seq_stop,
  output logic [4:0]             sel_prog,
  output logic [10:0]            sel_last_step,
  output logic [47:0]            mem_label,
  output logic [15:0][47:0]      prog_labels,
  output logic [1:0]             term_code,
  output logic                   reply_head,
  output logic                   alarm_reset,
  output logic [4:0]             bus_addr,
  output logic                   panel_lock,
  output logic                   srq
);

  typedef struct packed {
    logic                 ack;
    logic [31:0]          rdata;
    logic [15:0]          arg;
    logic [47:0]          text;
    logic [7:0]           last_op;
    logic [31:0]          reply0;
    logic [31:0]          reply1;
    logic [4:0]           sel_prog;
    logic [15:0][10:0]    last_step;
    logic                 exec_mode;
    lrcd_pkg::lrcd_run_type run_state;
    logic [3:0]           run_seq;
    logic                 seq_start;
    logic                 seq_stop;
    logic [47:0]          mem_label;
    logic [15:0][47:0]    prog_label;
    logic [7:0]           srq_en;
    logic [7:0]           fault_en;
    logic [7:0]           fault_latch;
    logic                 err_flag;
    logic [7:0]           err_code;
    logic [1:0]           term;
    logic                 head;
    logic [4:0]           bus_addr;
    logic                 panel_lock;
    logic                 alarm_rst;
    logic                 srq;
  } lrcd_state_type;

  lrcd_state_type cur_ff;
  lrcd_state_type nxt_ff;

  logic                  req;
  logic                  acc;
  logic                  cmd_go;
  lrcd_pkg::lrcd_op_type cmd_op;
  logic [5:0]            reg_off;
  logic [7:0]            summary;

  // One wait state: the request is answered at the second edge it is held
  assign req             = avs_read | avs_write;
  assign acc             = req & cur_ff.ack;
  assign avs_waitrequest = req & ~cur_ff.ack;
  assign avs_readdata    = cur_ff.rdata;
  assign reg_off         = {avs_address[5:2], 2'h0};
  assign cmd_go          = avs_write & cur_ff.ack & (reg_off == lrcd_pkg::OFF_CMD) & avs_byteenable[0];
  assign cmd_op          = lrcd_pkg::lrcd_op_type'(avs_writedata[7:0]);

  // Summary byte; power-on and sequence-over bits read as zero here
  always_comb begin
    summary                     = 8'h00;
    summary[lrcd_pkg::SUM_FAULT] = |cur_ff.fault_latch;
    summary[lrcd_pkg::SUM_ERR]   = cur_ff.err_flag;
    summary[lrcd_pkg::SUM_BUS]   = bus_srq;
  end

  // Byte-lane merge for partial writes
  function automatic logic [31:0] lrcd_merge(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0]  be);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        res[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return res;
  endfunction : lrcd_merge

  // Next-state logic: bus slave, command execution, latches
  always_comb begin
    logic        err_hit;
    logic [7:0]  err_val;
    logic [15:0] a;
    logic [31:0] w;
    err_hit = 1'b0;
    err_val = lrcd_pkg::ERR_NONE;
    a       = cur_ff.arg;
    w       = 32'h0000_0000;
    nxt_ff  = cur_ff;
    nxt_ff.seq_start = 1'b0;
    nxt_ff.seq_stop  = 1'b0;
    nxt_ff.alarm_rst = 1'b0;
    nxt_ff.ack       = req & ~cur_ff.ack;

    // Read data is captured at the first edge so it comes from a flop
    if (avs_read && !cur_ff.ack) begin
      unique case (reg_off)
        lrcd_pkg::OFF_CMD:     nxt_ff.rdata = {24'h000000, cur_ff.last_op};
        lrcd_pkg::OFF_ARG:     nxt_ff.rdata = {16'h0000, cur_ff.arg};
        lrcd_pkg::OFF_TEXT_LO: nxt_ff.rdata = cur_ff.text[31:0];
        lrcd_pkg::OFF_TEXT_HI: nxt_ff.rdata = {16'h0000, cur_ff.text[47:32]};
        lrcd_pkg::OFF_REPLY0:  nxt_ff.rdata = cur_ff.reply0;
        lrcd_pkg::OFF_REPLY1:  nxt_ff.rdata = cur_ff.reply1;
        lrcd_pkg::OFF_CONFIG:  nxt_ff.rdata = {15'h0000, cur_ff.run_state, cur_ff.bus_addr, cur_ff.panel_lock,
                                              cur_ff.head, cur_ff.term, cur_ff.exec_mode, cur_ff.sel_prog};
        lrcd_pkg::OFF_ERROR:   nxt_ff.rdata = {23'h000000, cur_ff.err_flag, cur_ff.err_code};
        default:               nxt_ff.rdata = 32'h0000_0000; // Unmapped reads as zero
      endcase
    end

    // A finished sequence drops back to stopped unless a command overrides
    if (seq_done && cur_ff.run_state != lrcd_pkg::RS_STOPPED) begin
      nxt_ff.run_state = lrcd_pkg::RS_STOPPED;
    end

    // Plain register writes; unmapped and read-only offsets ignore writes
    if (avs_write && cur_ff.ack) begin
      if (reg_off == lrcd_pkg::OFF_ARG) begin
        w = lrcd_merge({16'h0000, cur_ff.arg}, avs_writedata, avs_byteenable);
        nxt_ff.arg = w[15:0];
      end else if (reg_off == lrcd_pkg::OFF_TEXT_LO) begin
        nxt_ff.text[31:0] = lrcd_merge(cur_ff.text[31:0], avs_writedata, avs_byteenable);
      end else if (reg_off == lrcd_pkg::OFF_TEXT_HI) begin
        w = lrcd_merge({16'h0000, cur_ff.text[47:32]}, avs_writedata, avs_byteenable);
        nxt_ff.text[47:32] = w[15:0];
      end
    end

    // Command execution: argument and text are staged beforehand
    if (cmd_go) begin
      nxt_ff.last_op = avs_writedata[7:0];
      unique case (cmd_op)
        lrcd_pkg::OP_PROG_SEL: begin
          if (a >= lrcd_pkg::PROG_MIN && a <= lrcd_pkg::PROG_MAX) nxt_ff.sel_prog = a[4:0];
          else begin err_hit = 1'b1; err_val = lrcd_pkg::ERR_ARG; end
        end
        lrcd_pkg::OP_PROG_Q:     nxt_ff.reply0 = {27'h0000000, cur_ff.sel_prog};
        lrcd_pkg::OP_LAST_STEP: begin
          if (a >= lrcd_pkg::STEP_MIN && a <= lrcd_pkg::STEP_MAX)
            nxt_ff.last_step[4'(cur_ff.sel_prog - 5'h01)] = a[10:0];
          else begin err_hit = 1'b1; err_val = lrcd_pkg::ERR_ARG; end
        end
        lrcd_pkg::OP_ARM: begin
          if (a <= lrcd_pkg::FLAG_MAX) nxt_ff.exec_mode = a[0];
          else begin err_hit = 1'b1; err_val = lrcd_pkg::ERR_ARG; end
        end
        lrcd_pkg::OP_RUN: begin
          if (!cur_ff.exec_mode) begin err_hit = 1'b1; err_val = lrcd_pkg::ERR_MODE; end
          else if (a >= lrcd_pkg::PROG_MIN && a <= lrcd_pkg::SEQ_MAX) begin
            nxt_ff.run_state = lrcd_pkg::RS_SEQUENCER_STATE_QUERY;
            nxt_ff.run_seq   = a[3:0];
            nxt_ff.seq_start = 1'b1;
          end else begin err_hit = 1'b1; err_val = lrcd_pkg::ERR_ARG; end
        end
        lrcd_pkg::OP_PAUSE: begin
          if (!cur_ff.exec_mode) begin err_hit = 1'b1; err_val = lrcd_pkg::ERR_MODE; end
          else if (a > lrcd_pkg::FLAG_MAX) begin err_hit = 1'b1; err_val = lrcd_pkg::ERR_ARG; end
          else if (a[0] && cur_ff.run_state == lrcd_pkg::RS_SEQUENCER_STATE_QUERY) nxt_ff.run_state = lrcd_pkg::RS_PAUSED;
          else if (!a[0] && cur_ff.run_state == lrcd_pkg::RS_PAUSED) nxt_ff.run_state = lrcd_pkg::RS_SEQUENCER_STATE_QUERY;
        end
        lrcd_pkg::OP_STOP: begin
          if (!cur_ff.exec_mode) begin err_hit = 1'b1; err_val = lrcd_pkg::ERR_MODE; end
          else begin
            nxt_ff.run_state = lrcd_pkg::RS_STOPPED;
            nxt_ff.seq_stop  = 1'b1;
          end
        end
        lrcd_pkg::OP_STATE_Q: begin
          nxt_ff.reply0 = {11'h000, run_prog, 4'h0, cur_ff.run_seq, 6'h00, cur_ff.run_state};
          nxt_ff.reply1 = {2'h0, run_loop, 5'h00, run_step};
        end
        lrcd_pkg::OP_KIND_Q:     nxt_ff.reply0 = {28'h0000000, seq_kind};
        lrcd_pkg::OP_MEM_LABEL:  nxt_ff.mem_label = cur_ff.text;
        lrcd_pkg::OP_PROG_LBL: begin
          if (a >= lrcd_pkg::PROG_MIN && a <= lrcd_pkg::PROG_MAX)
            nxt_ff.prog_label[4'(a[4:0] - 5'h01)] = cur_ff.text;
          else begin err_hit = 1'b1; err_val = lrcd_pkg::ERR_ARG; end
        end
        lrcd_pkg::OP_SRQ_EN: begin
          if (a <= lrcd_pkg::BYTE_MAX) nxt_ff.srq_en = a[7:0];
          else begin err_hit = 1'b1; err_val = lrcd_pkg::ERR_ARG; end
        end
        lrcd_pkg::OP_SRQ_EN_Q:   nxt_ff.reply0 = {24'h000000, cur_ff.srq_en};
        lrcd_pkg::OP_FAULT_EN: begin
          if (a <= lrcd_pkg::BYTE_MAX) nxt_ff.fault_en = a[7:0];
          else begin err_hit = 1'b1; err_val = lrcd_pkg::ERR_ARG; end
        end
        lrcd_pkg::OP_FAULT_EN_Q: nxt_ff.reply0 = {24'h000000, cur_ff.fault_en};
        lrcd_pkg::OP_SUMMARY_Q:  nxt_ff.reply0 = {24'h000000, summary};
        lrcd_pkg::OP_ALARM_Q: begin
          nxt_ff.reply0      = {24'h000000, cur_ff.fault_latch};
          nxt_ff.fault_latch = 8'h00;
        end
        lrcd_pkg::OP_LIVE_Q:     nxt_ff.reply0 = {24'h000000, live_cond};
        lrcd_pkg::OP_IDENT_Q:    nxt_ff.reply0 = {MODEL_CODE, REVISION_CODE};
        lrcd_pkg::OP_TERM: begin
          if (a <= lrcd_pkg::TERM_MAX) nxt_ff.term = a[1:0];
          else begin err_hit = 1'b1; err_val = lrcd_pkg::ERR_ARG; end
        end
        lrcd_pkg::OP_TERM_Q:     nxt_ff.reply0 = {30'h00000000, cur_ff.term};
        lrcd_pkg::OP_HEAD: begin
          if (a <= lrcd_pkg::FLAG_MAX) nxt_ff.head = a[0];
          else begin err_hit = 1'b1; err_val = lrcd_pkg::ERR_ARG; end
        end
        lrcd_pkg::OP_HEAD_Q:     nxt_ff.reply0 = {31'h00000000, cur_ff.head};
        lrcd_pkg::OP_ERR_Q: begin
          nxt_ff.reply0   = {24'h000000, cur_ff.err_code};
          nxt_ff.err_flag = 1'b0;
        end
        lrcd_pkg::OP_ALARM_RST:  nxt_ff.alarm_rst = 1'b1;
        lrcd_pkg::OP_ROUTE: begin
          if (a <= 16'(lrcd_pkg::ADDR_ALL)) nxt_ff.bus_addr = a[4:0];
          else begin err_hit = 1'b1; err_val = lrcd_pkg::ERR_ARG; end
        end
        lrcd_pkg::OP_ROUTE_Q: begin
          if (cur_ff.bus_addr == lrcd_pkg::ADDR_ALL) nxt_ff.reply0 = 32'h0000_0000;
          else nxt_ff.reply0 = {27'h0000000, cur_ff.bus_addr};
        end
        lrcd_pkg::OP_ROUTE_HOME: nxt_ff.bus_addr = lrcd_pkg::ADDR_HOME;
        lrcd_pkg::OP_LOCK: begin
          if (a <= lrcd_pkg::FLAG_MAX) nxt_ff.panel_lock = a[0];
          else begin err_hit = 1'b1; err_val = lrcd_pkg::ERR_ARG; end
        end
        default: begin
          err_hit = 1'b1;
          err_val = lrcd_pkg::ERR_SYNTAX;
        end
      endcase
    end

    // Device clear wins over any route command in the same cycle
    if (dev_clear) nxt_ff.bus_addr = lrcd_pkg::ADDR_HOME;

    // Enabled live faults set latch bits; a set beats the query's clear
    nxt_ff.fault_latch = nxt_ff.fault_latch | (live_cond & cur_ff.fault_en);

    // Errors record last; the error query itself never raises one
    if (err_hit) begin
      nxt_ff.err_flag = 1'b1;
      nxt_ff.err_code = err_val;
    end

    // Service request from enabled summary bits, one cycle behind
    nxt_ff.srq = |(summary & cur_ff.srq_en);
  end

  // State register
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      cur_ff           <= '0;
      cur_ff.sel_prog  <= lrcd_pkg::PROG_RST;
      cur_ff.last_step <= {16{lrcd_pkg::LAST_RST}};
      cur_ff.run_state <= lrcd_pkg::RS_STOPPED;
    end else begin
      cur_ff <= nxt_ff;
    end
  end

  // Outputs straight from the state flops; sel_last_step goes through a mux on sel_prog
  assign exec_mode     = cur_ff.exec_mode;
  assign run_state     = cur_ff.run_state;
  assign run_seq       = cur_ff.run_seq;
  assign seq_start     = cur_ff.seq_start;
  assign seq_stop      = cur_ff.seq_stop;
  assign sel_prog      = cur_ff.sel_prog;
  assign sel_last_step = cur_ff.last_step[4'(cur_ff.sel_prog - 5'h01)];
  assign mem_label     = cur_ff.mem_label;
  assign prog_labels   = cur_ff.prog_label;
  assign term_code     = cur_ff.term;
  assign reply_head    = cur_ff.head;
  assign alarm_reset   = cur_ff.alarm_rst;
  assign bus_addr      = cur_ff.bus_addr;
  assign panel_lock    = cur_ff.panel_lock;
  assign srq           = cur_ff.srq;

  // Checks on the command effects
  default clocking lrcd_cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);

  chk_prog_select: assert property (
    cmd_go && cmd_op == lrcd_pkg::OP_PROG_SEL && cur_ff.arg >= lrcd_pkg::PROG_MIN
      && cur_ff.arg <= lrcd_pkg::PROG_MAX |=> sel_prog == $past(cur_ff.arg[4:0]))
    else $error("selected program not taken from argument");

  chk_run_starts: assert property (
    cmd_go && cmd_op == lrcd_pkg::OP_RUN && exec_mode && cur_ff.arg >= lrcd_pkg::PROG_MIN
      && cur_ff.arg <= lrcd_pkg::SEQ_MAX |=> seq_start && run_state == lrcd_pkg::RS_SEQUENCER_STATE_QUERY ##1 !seq_start)
    else $error("run did not start a single pulse");

  chk_stop_halts: assert property (
    cmd_go && cmd_op == lrcd_pkg::OP_STOP && exec_mode |=> run_state == lrcd_pkg::RS_STOPPED && seq_stop)
    else $error("stop did not halt the sequence");

  chk_arm_guard: assert property (
    cmd_go && (cmd_op == lrcd_pkg::OP_RUN || cmd_op == lrcd_pkg::OP_STOP) && !exec_mode && !seq_done
      |=> $stable(run_state) && cur_ff.err_flag && cur_ff.err_code == lrcd_pkg::ERR_MODE)
    else $error("sequence command acted outside execute mode");

  chk_err_clear: assert property (
    cmd_go && cmd_op == lrcd_pkg::OP_ERR_Q |=> !cur_ff.err_flag && cur_ff.reply0[7:0] == $past(cur_ff.err_code))
    else $error("error query did not clear the flag");

  chk_fault_hold: assert property (
    !(cmd_go && cmd_op == lrcd_pkg::OP_ALARM_Q) |=> (cur_ff.fault_latch & $past(cur_ff.fault_latch))
      == $past(cur_ff.fault_latch))
    else $error("fault latch bit dropped without a query");

  chk_route_home: assert property (
    cmd_go && cmd_op == lrcd_pkg::OP_ROUTE_HOME |=> bus_addr == lrcd_pkg::ADDR_HOME)
    else $error("home command left a nonzero address");

  chk_bcast_reply: assert property (
    cmd_go && cmd_op == lrcd_pkg::OP_ROUTE_Q && bus_addr == lrcd_pkg::ADDR_ALL |=> cur_ff.reply0 == 32'h0000_0000)
    else $error("broadcast address query did not return zero");

  chk_dev_clear: assert property (
    dev_clear |=> bus_addr == lrcd_pkg::ADDR_HOME)
    else $error("device clear did not home the address");

  chk_bus_answer: assert property (
    req && !cur_ff.ack |=> !avs_waitrequest || !req)
    else $error("bus request not answered after one wait state");

endmodule : lrcd_decoder

// ===== design/lrcd_pkg.sv
/*
  Constants and types for the remote command decoder: register offsets,
  command codes, run states, error codes and argument limits.
  Assumes a 32-bit Avalon-MM slave with byte addresses on a 6-bit bus.
*/
package lrcd_pkg;

  // Register byte offsets
  localparam logic [5:0] OFF_CMD     = 6'h00;
  localparam logic [5:0] OFF_ARG     = 6'h04;
  localparam logic [5:0] OFF_TEXT_LO = 6'h08;
  localparam logic [5:0] OFF_TEXT_HI = 6'h0c;
  localparam logic [5:0] OFF_REPLY0  = 6'h10;
  localparam logic [5:0] OFF_REPLY1  = 6'h14;
  localparam logic [5:0] OFF_CONFIG  = 6'h18;
  localparam logic [5:0] OFF_ERROR   = 6'h1c;

  // Argument limits
  localparam logic [15:0] PROG_MIN  = 16'h0001;
  localparam logic [15:0] PROG_MAX  = 16'h0010;
  localparam logic [15:0] STEP_MIN  = 16'h0001;
  localparam logic [15:0] STEP_MAX  = 16'h0400;
  localparam logic [15:0] SEQ_MAX   = 16'h0008;
  localparam logic [15:0] BYTE_MAX  = 16'h00ff;
  localparam logic [15:0] TERM_MAX  = 16'h0003;
  localparam logic [15:0] FLAG_MAX  = 16'h0001;
  localparam logic [4:0]  ADDR_ALL  = 5'h10;
  localparam logic [4:0]  ADDR_HOME = 5'h00;

  // Reset values
  localparam logic [4:0]  PROG_RST  = 5'h01;
  localparam logic [10:0] LAST_RST  = 11'h001;

  // Error codes
  localparam logic [7:0] ERR_NONE   = 8'h00;
  localparam logic [7:0] ERR_SYNTAX = 8'h01;
  localparam logic [7:0] ERR_ARG    = 8'h02;
  localparam logic [7:0] ERR_MODE   = 8'h0f;

  // Summary byte bit positions
  localparam int SUM_FAULT = 0;
  localparam int SUM_ERR   = 3;
  localparam int SUM_BUS   = 4;

  // Sequence kind codes as reported by the sequencer
  localparam logic [3:0] KIND_VOLTAGE = 4'h1;
  localparam logic [3:0] KIND_CURRENT = 4'h2;
  localparam logic [3:0] KIND_POWER   = 4'h5;
  localparam logic [3:0] KIND_FAST_I  = 4'hb;
  localparam logic [3:0] KIND_FAST_G  = 4'hc;

  typedef enum logic [1:0] {
    RS_STOPPED = 2'h1,
    RS_SEQUENCER_STATE_QUERY = 2'h2,
    RS_PAUSED  = 2'h3
  } lrcd_run_type;

  typedef enum logic [7:0] {
    OP_PROG_SEL   = 8'h01, OP_PROG_Q    = 8'h02, OP_LAST_STEP  = 8'h03,
    OP_ARM        = 8'h04, OP_RUN       = 8'h05, OP_PAUSE      = 8'h06,
    OP_STOP       = 8'h07, OP_STATE_Q   = 8'h08, OP_KIND_Q     = 8'h09,
    OP_MEM_LABEL  = 8'h0a, OP_PROG_LBL  = 8'h0b, OP_SRQ_EN     = 8'h0c,
    OP_SRQ_EN_Q   = 8'h0d, OP_FAULT_EN  = 8'h0e, OP_FAULT_EN_Q = 8'h0f,
    OP_SUMMARY_Q  = 8'h10, OP_ALARM_Q   = 8'h11, OP_LIVE_Q     = 8'h12,
    OP_IDENT_Q    = 8'h13, OP_TERM      = 8'h14, OP_TERM_Q     = 8'h15,
    OP_HEAD       = 8'h16, OP_HEAD_Q    = 8'h17, OP_ERR_Q      = 8'h18,
    OP_ALARM_RST  = 8'h19, OP_ROUTE     = 8'h1a, OP_ROUTE_Q    = 8'h1b,
    OP_ROUTE_HOME = 8'h1c, OP_LOCK      = 8'h1d
  } lrcd_op_type;

endpackage : lrcd_pkg

// ===== dv/lrcd_seq_model.sv
/*
  Sequencer stand-in for the command decoder: reports kind, position and
  loop count, and ends a run by itself. Assumes the decoder's run_state and
  sel_prog outputs and one clock shared with it.
*/
`timescale 1ns/1ps
module lrcd_seq_model #(
  parameter logic [10:0] DONE_AT = 11'h03c
) (
  input  wire logic        ref_clk,
  input  wire logic        rstn,
  input  wire logic [1:0]  run_state,
  input  wire logic [4:0]  sel_prog,
  output logic             seq_done,
  output logic [3:0]       seq_kind,
  output logic [4:0]       run_prog,
  output logic [10:0]      run_step,
  output logic [13:0]      run_loop
);
  // Step advances only while sequencer_state_query, so a paused state read is repeatable
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) run_step <= '0;
    else if (run_state == 2'h1) run_step <= '0;
    else if (run_state == 2'h2) run_step <= run_step + 11'h001;
  end
  // Finish is a level held one cycle; the decoder must return to stopped
  assign seq_done = (run_step == DONE_AT);
  assign seq_kind = lrcd_pkg::KIND_FAST_I;
  assign run_prog = sel_prog;
  assign run_loop = 14'h0003;
endmodule : lrcd_seq_model

// ===== dv/testbench.sv
/*
  Self-checking bench for the command decoder: Avalon tasks, a table of
  set/query pairs, then hand tests. Assumes a 50 MHz clock, one wait state.
*/
`timescale 1ns/1ps
module testbench;
  typedef struct {logic [7:0] s; logic [15:0] a; logic [7:0] q; logic [31:0] e;} lrcd_row_type;
  logic              ref_clk = 1'h0, rstn = 1'h0, avs_read = 1'h0, avs_write = 1'h0;
  logic              bus_srq = 1'h0, dev_clear = 1'h0;
  logic [5:0]        avs_address = '0;
  logic [31:0]       avs_writedata = '0, avs_readdata, q;
  logic [3:0]        avs_byteenable = 4'hf;
  logic [7:0]        live_cond = '0;
  logic              avs_waitrequest, seq_done, exec_mode, seq_start, seq_stop, reply_head;
  logic              alarm_reset, panel_lock, srq;
  logic [3:0]        seq_kind, run_seq;
  logic [4:0]        run_prog, sel_prog, bus_addr;
  logic [10:0]       run_step, sel_last_step;
  logic [13:0]       run_loop;
  logic [1:0]        run_state, term_code;
  logic [47:0]       mem_label;
  logic [15:0][47:0] prog_labels;
  int                n_errors = 0, comparisons = 0, n_rst = 0, i;
  lrcd_row_type      rows [8] = '{
    '{lrcd_pkg::OP_PROG_SEL, 16'h0005, lrcd_pkg::OP_PROG_Q, 32'h5},
    '{lrcd_pkg::OP_SRQ_EN, 16'h00a5, lrcd_pkg::OP_SRQ_EN_Q, 32'ha5},
    '{lrcd_pkg::OP_FAULT_EN, 16'h003c, lrcd_pkg::OP_FAULT_EN_Q, 32'h3c},
    '{lrcd_pkg::OP_TERM, 16'h0003, lrcd_pkg::OP_TERM_Q, 32'h3},
    '{lrcd_pkg::OP_TERM, 16'h0000, lrcd_pkg::OP_TERM_Q, 32'h0},
    '{lrcd_pkg::OP_HEAD, 16'h0001, lrcd_pkg::OP_HEAD_Q, 32'h1},
    '{lrcd_pkg::OP_ROUTE, 16'h0010, lrcd_pkg::OP_ROUTE_Q, 32'h0},
    '{lrcd_pkg::OP_ROUTE, 16'h000f, lrcd_pkg::OP_ROUTE_Q, 32'hf}};

  // Identity values are arbitrary, chosen to differ from the defaults
  lrcd_decoder #(.MODEL_CODE(16'h1234), .REVISION_CODE(16'h0056)) dut (.*);
  lrcd_seq_model model (.*);

  always #10 ref_clk = ~ref_clk;
  // Pulses are counted so a stuck-high strobe shows as a count above one
  always @(posedge ref_clk) if (alarm_reset === 1'h1) n_rst++;

  task automatic results();
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : results

  task automatic ck(input string n, input logic [31:0] s, input logic [31:0] e);
    comparisons++;
    if (s !== e) begin
      n_errors++;
      $display("unexpected %s expected %h seen %h", n, e, s);
    end
  endtask : ck

  // Request held until waitrequest is sampled low at a rising edge; data taken at that edge
  task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
    int n;
    @(posedge ref_clk);
    avs_address <= a;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= d;
    for (n = 0; n < 16; n++) begin
      @(posedge ref_clk);
      if (avs_waitrequest === 1'h0) break;
    end
    if (n == 16) begin
      ck("waitrequest", 1, 0);
      results();
    end
    q = avs_readdata;
    avs_write <= 1'h0;
    avs_read <= 1'h0;
    @(negedge ref_clk);
  endtask : bus

  task automatic cmd(input logic [7:0] op, input logic [15:0] arg);
    bus(1'h1, lrcd_pkg::OFF_ARG, {16'h0, arg});
    bus(1'h1, lrcd_pkg::OFF_CMD, {24'h0, op});
  endtask : cmd

  task automatic qy(input logic [7:0] op);
    cmd(op, '0);
    bus(1'h0, lrcd_pkg::OFF_REPLY0, '0);
  endtask : qy

  initial begin
    repeat (2) @(posedge ref_clk);
    rstn <= 1'h1;
    @(negedge ref_clk);
    ck("sel_prog", sel_prog, 1);
    ck("run_state", run_state, 1);
    // Ordinary set-then-query pairs
    for (i = 0; i < 8; i++) begin
      cmd(rows[i].s, rows[i].a);
      qy(rows[i].q);
      ck("reply", q, rows[i].e);
    end
    ck("format", {term_code, reply_head}, 3'h1);
    bus(1'h0, lrcd_pkg::OFF_CONFIG, '0);
    ck("config", q, 32'h0000bd05);
    // Run outside execute mode is refused with a mode error
    cmd(lrcd_pkg::OP_RUN, 16'h0003);
    ck("run_state", run_state, 1);
    bus(1'h0, lrcd_pkg::OFF_ERROR, '0);
    ck("error", q, 32'h10f);
    qy(lrcd_pkg::OP_ERR_Q);
    ck("err_q", q[7:0], 8'h0f);
    bus(1'h0, lrcd_pkg::OFF_ERROR, '0);
    ck("err_flag", q[8], 0);
    cmd(lrcd_pkg::OP_ARM, 16'h0001);
    ck("exec_mode", exec_mode, 1);
    cmd(lrcd_pkg::OP_RUN, 16'h0009);
    bus(1'h0, lrcd_pkg::OFF_ERROR, '0);
    ck("error", q, 32'h102);
    cmd(lrcd_pkg::OP_RUN, 16'h0008);
    ck("run", {run_seq, 2'h0, run_state}, 8'h82);
    cmd(lrcd_pkg::OP_PAUSE, 16'h0001);
    ck("run_state", run_state, 3);
    qy(lrcd_pkg::OP_STATE_Q);
    ck("state0", q, 32'h00050803);
    bus(1'h0, lrcd_pkg::OFF_REPLY1, '0);
    ck("state1", q, {2'h0, run_loop, 5'h0, run_step});
    cmd(lrcd_pkg::OP_PAUSE, 16'h0000);
    ck("run_state", run_state, 2);
    for (i = 0; i < 200 && run_state !== 2'h1; i++) @(negedge ref_clk);
    ck("done", run_state, 1);
    cmd(lrcd_pkg::OP_RUN, 16'h0001);
    cmd(lrcd_pkg::OP_PAUSE, 16'h0001);
    cmd(lrcd_pkg::OP_STOP, '0);
    ck("stop", run_state, 1);
    cmd(lrcd_pkg::OP_ARM, '0);
    ck("exec_mode", exec_mode, 0);
    qy(lrcd_pkg::OP_KIND_Q);
    ck("kind", q, {28'h0, lrcd_pkg::KIND_FAST_I});
    // Last step at its upper bound, one past it, then another program
    cmd(lrcd_pkg::OP_LAST_STEP, 16'h0400);
    cmd(lrcd_pkg::OP_LAST_STEP, 16'h0401);
    ck("last_step", sel_last_step, 11'h400);
    cmd(lrcd_pkg::OP_PROG_SEL, 16'h0002);
    cmd(lrcd_pkg::OP_PROG_SEL, 16'h0011);
    ck("prog", {sel_prog, sel_last_step}, {5'h02, 11'h001});
    // Device clear after addressing a missing unit
    cmd(lrcd_pkg::OP_ROUTE, 16'h0007);
    @(posedge ref_clk);
    dev_clear <= 1'h1;
    @(posedge ref_clk);
    dev_clear <= 1'h0;
    @(negedge ref_clk);
    ck("bus_addr", bus_addr, 0);
    cmd(lrcd_pkg::OP_ROUTE, 16'h0009);
    cmd(lrcd_pkg::OP_ROUTE_HOME, '0);
    ck("bus_addr", bus_addr, 0);
    // Only enabled fault bits latch; the latch outlives the condition
    @(posedge ref_clk);
    live_cond <= 8'h84;
    bus_srq <= 1'h1;
    qy(lrcd_pkg::OP_LIVE_Q);
    ck("live", q, 32'h84);
    ck("srq", srq, 1);
    @(posedge ref_clk);
    live_cond <= 8'h00;
    qy(lrcd_pkg::OP_SUMMARY_Q);
    ck("summary", q, 32'h19);
    qy(lrcd_pkg::OP_ALARM_Q);
    ck("fault", q, 32'h04);
    qy(lrcd_pkg::OP_ALARM_Q);
    ck("fault", q, 32'h00);
    ck("srq", srq, 0);
    qy(lrcd_pkg::OP_IDENT_Q);
    ck("ident", q, 32'h12340056);
    cmd(lrcd_pkg::OP_LOCK, 16'h0001);
    ck("panel_lock", panel_lock, 1);
    cmd(lrcd_pkg::OP_LOCK, '0);
    ck("panel_lock", panel_lock, 0);
    cmd(lrcd_pkg::OP_ALARM_RST, '0);
    bus(1'h1, lrcd_pkg::OFF_TEXT_LO, 32'h64636261);
    bus(1'h1, lrcd_pkg::OFF_TEXT_HI, 32'h00006665);
    cmd(lrcd_pkg::OP_MEM_LABEL, '0);
    ck("mem_label", mem_label === 48'h666564636261, 1);
    cmd(lrcd_pkg::OP_PROG_LBL, 16'h0010);
    ck("prog_label", prog_labels[15] === 48'h666564636261, 1);
    // Counted long after the strobe, so a stuck pulse shows as more than one
    ck("alarm_reset", n_rst, 1);
    // Reset with the sequence stopped brings settings back to their reset values
    @(posedge ref_clk);
    rstn <= 1'h0;
    @(posedge ref_clk);
    rstn <= 1'h1;
    @(negedge ref_clk);
    ck("reset", {sel_prog, bus_addr, reply_head, exec_mode, run_state}, 14'h0201);
    results();
  end
endmodule : testbench
